// ===== core/ppm_top.sv
// Overview of operation
// - Both select bits set on an analog pin switch off its driver and input.
// - A set comparator pin-disable bit switches off driver and input.
// - A pin chosen by the comparator input select is switched off too.
// - A pin given to a serial unit takes its direction from that unit.
// - An empty select code gives no input and drives low when output.
// - Slow input pin with select 01 leaves GPIO for the oscillator.
// - Slow oscillator without bypass puts both pins in crystal mode.
// - Slow oscillator with bypass takes a clock; its out pin stays GPIO.
// - Any select bit on the slow out pin kills GPIO and drives low when output.
// - Fast input pin with select 01 leaves GPIO for the oscillator.
// - Fast oscillator without bypass puts both pins in crystal mode.
// - Fast oscillator with bypass takes a clock; its out pin stays GPIO.
// - Any select bit on the fast out pin kills GPIO and drives low when output.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`include "ppm_params.svh"
`default_nettype none

module ppm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [25:0] alt_a_out,
  input wire logic [25:0] alt_b_out,
  input wire logic [25:0] serial_oe,
  input wire logic [25:0] pad_in,
  output logic [25:0] pad_out,
  output logic [25:0] pad_oe,
  output logic [25:0] pad_ie,
  output logic [25:0] gpio_in,
  output logic [25:0] func_in,
  output logic [25:0] analog_en,
  output logic slow_osc_crystal,
  output logic slow_osc_ext_clock,
  output logic fast_osc_crystal,
  output logic fast_osc_ext_clock
);
  import ppm_pkg::*;

  // ========================================================================
  // Pin function table: P2.2..P2.7, P3.0..P3.7, P4.0..P4.7, PJ.4..PJ.7.
  localparam ppm_pin_s PIN_TBL [0:`PPM_NPIN-1] = '{
    '{PPM_OO, PPM_SR, PPM_NO, 5'h00},
    '{PPM_TM, PPM_SR, PPM_AN, 5'h1a},
    '{PPM_TM, PPM_SR, PPM_AN, 5'h1b},
    '{PPM_TM, PPM_SR, PPM_NO, 5'h00},
    '{PPM_OO, PPM_SR, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h1c},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h1d},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h1e},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h1f},
    '{PPM_TM, PPM_OO, PPM_OO, 5'h00},
    '{PPM_TM, PPM_OO, PPM_OO, 5'h00},
    '{PPM_TM, PPM_NO, PPM_NO, 5'h00},
    '{PPM_TM, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h00},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h00},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h00},
    '{PPM_NO, PPM_NO, PPM_AN, 5'h00},
    '{PPM_TM, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00},
    '{PPM_NO, PPM_NO, PPM_NO, 5'h00}
  };

  localparam int PAD = `PPM_DW - `PPM_NPIN;

  // ========================================================================
  // Register state.
  logic [25:0] dir_q, dir_d;
  logic [25:0] sello_q, sello_d;
  logic [25:0] selhi_q, selhi_d;
  logic [25:0] gout_q, gout_d;
  logic [15:0] cpd_q, cpd_d;
  logic [9:0] csel_q, csel_d;
  logic [1:0] osc_q, osc_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q;
  logic hresp_q;
  logic acc;
  logic [7:0] ra;

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;

  // ========================================================================
  // Bus slave: zero wait states, reads registered at the address phase.
  always_comb begin
    dir_d = dir_q;
    sello_d = sello_q;
    selhi_d = selhi_q;
    gout_d = gout_q;
    cpd_d = cpd_q;
    csel_d = csel_q;
    osc_d = osc_q;
    acc = hsel && hready && htrans[`PPM_HTRANS_NSEQ_BIT];
    ra = haddr[`PPM_AW-1:0];
    wr_pend_d = acc && hwrite && (hsize == `PPM_HSIZE_WORD);
    wr_addr_d = wr_pend_d ? ra : wr_addr_q;
    hrdata_d = `PPM_RST_WORD;
    if (acc && !hwrite) begin
      if (ra == `PPM_OFF_DIR) begin
        hrdata_d = {{PAD{1'h0}}, dir_q};
      end else if (ra == `PPM_OFF_SELLO) begin
        hrdata_d = {{PAD{1'h0}}, sello_q};
      end else if (ra == `PPM_OFF_SELHI) begin
        hrdata_d = {{PAD{1'h0}}, selhi_q};
      end else if (ra == `PPM_OFF_GOUT) begin
        hrdata_d = {{PAD{1'h0}}, gout_q};
      end else if (ra == `PPM_OFF_CPD) begin
        hrdata_d = {16'h0, cpd_q};
      end else if (ra == `PPM_OFF_CSEL) begin
        hrdata_d = {22'h0, csel_q};
      end else if (ra == `PPM_OFF_OSC) begin
        hrdata_d = {30'h0, osc_q};
      end else if (ra == `PPM_OFF_GIN) begin
        hrdata_d = {{PAD{1'h0}}, gpio_in};
      end else begin
        hrdata_d = `PPM_RST_WORD;
      end
    end
    if (wr_pend_q) begin
      if (wr_addr_q == `PPM_OFF_DIR) begin
        dir_d = hwdata[`PPM_NPIN-1:0];
      end else if (wr_addr_q == `PPM_OFF_SELLO) begin
        sello_d = hwdata[`PPM_NPIN-1:0];
      end else if (wr_addr_q == `PPM_OFF_SELHI) begin
        selhi_d = hwdata[`PPM_NPIN-1:0];
      end else if (wr_addr_q == `PPM_OFF_GOUT) begin
        gout_d = hwdata[`PPM_NPIN-1:0];
      end else if (wr_addr_q == `PPM_OFF_CPD) begin
        cpd_d = hwdata[`PPM_NCMP-1:0];
      end else if (wr_addr_q == `PPM_OFF_CSEL) begin
        csel_d = hwdata[`PPM_CSEL_W-1:0];
      end else if (wr_addr_q == `PPM_OFF_OSC) begin
        osc_d = hwdata[`PPM_OSC_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= 26'h0;
      sello_q <= 26'h0;
      selhi_q <= 26'h0;
      gout_q <= 26'h0;
      cpd_q <= 16'h0;
      csel_q <= 10'h0;
      osc_q <= 2'h0;
      wr_pend_q <= 1'h0;
      wr_addr_q <= 8'h0;
      hrdata_q <= `PPM_RST_WORD;
      hreadyout_q <= 1'h1;
      hresp_q <= 1'h0;
    end else begin
      dir_q <= dir_d;
      sello_q <= sello_d;
      selhi_q <= selhi_d;
      gout_q <= gout_d;
      cpd_q <= cpd_d;
      csel_q <= csel_d;
      osc_q <= osc_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'h1;
      hresp_q <= 1'h0;
    end
  end

  // ========================================================================
  // Oscillator pin ownership.
  logic s_take, s_ie, s_tout, s_xtal, s_ext;
  logic f_take, f_ie, f_tout, f_xtal, f_ext;
  logic [25:0] osc_take, osc_ie;
  logic slow_xtal_q, slow_ext_q, fast_xtal_q, fast_ext_q;

  ppm_osc_sel u_slow (
    .in_sel_hi(selhi_q[`PPM_PIN_SLOW_IN]),
    .in_sel_lo(sello_q[`PPM_PIN_SLOW_IN]),
    .bypass(osc_q[`PPM_F_SBYP]),
    .take_in(s_take),
    .in_ie(s_ie),
    .take_out(s_tout),
    .crystal(s_xtal),
    .ext_clock(s_ext)
  );

  ppm_osc_sel u_fast (
    .in_sel_hi(selhi_q[`PPM_PIN_FAST_IN]),
    .in_sel_lo(sello_q[`PPM_PIN_FAST_IN]),
    .bypass(osc_q[`PPM_F_FBYP]),
    .take_in(f_take),
    .in_ie(f_ie),
    .take_out(f_tout),
    .crystal(f_xtal),
    .ext_clock(f_ext)
  );

  always_comb begin
    osc_take = 26'h0;
    osc_ie = 26'h0;
    osc_take[`PPM_PIN_SLOW_IN] = s_take;
    osc_ie[`PPM_PIN_SLOW_IN] = s_ie;
    osc_take[`PPM_PIN_SLOW_OUT] = s_tout;
    osc_take[`PPM_PIN_FAST_IN] = f_take;
    osc_ie[`PPM_PIN_FAST_IN] = f_ie;
    osc_take[`PPM_PIN_FAST_OUT] = f_tout;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_xtal_q <= 1'h0;
      slow_ext_q <= 1'h0;
      fast_xtal_q <= 1'h0;
      fast_ext_q <= 1'h0;
    end else begin
      slow_xtal_q <= s_xtal;
      slow_ext_q <= s_ext;
      fast_xtal_q <= f_xtal;
      fast_ext_q <= f_ext;
    end
  end

  assign slow_osc_crystal = slow_xtal_q;
  assign slow_osc_ext_clock = slow_ext_q;
  assign fast_osc_crystal = fast_xtal_q;
  assign fast_osc_ext_clock = fast_ext_q;

  // ========================================================================
  // Pin cells.
  genvar gi;
  generate
    for (gi = 0; gi < `PPM_NPIN; gi++) begin : g_pin
      logic [3:0] ch;
      logic cmp_off;
      assign ch = PIN_TBL[gi].cch[3:0];
      assign cmp_off = PIN_TBL[gi].cch[4] && (cpd_q[ch]
        || (csel_q[`PPM_F_CPEN] && csel_q[`PPM_F_CPOS] == ch)
        || (csel_q[`PPM_F_CNEN] && csel_q[`PPM_F_CNEG] == ch));
      ppm_pin_cell u_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .tbl(PIN_TBL[gi]),
        .dir(dir_q[gi]),
        .sel_hi(selhi_q[gi]),
        .sel_lo(sello_q[gi]),
        .gpio_out(gout_q[gi]),
        .alt_a_out(alt_a_out[gi]),
        .alt_b_out(alt_b_out[gi]),
        .serial_oe(serial_oe[gi]),
        .cmp_off(cmp_off),
        .osc_take(osc_take[gi]),
        .osc_ie(osc_ie[gi]),
        .pad_in(pad_in[gi]),
        .pad_out_q(pad_out[gi]),
        .pad_oe_q(pad_oe[gi]),
        .pad_ie_q(pad_ie[gi]),
        .gpio_in_q(gpio_in[gi]),
        .func_in_q(func_in[gi]),
        .analog_en_q(analog_en[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Checks.
  AST_SLOW_TAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_take |=> !pad_oe[`PPM_PIN_SLOW_IN] && !gpio_in[`PPM_PIN_SLOW_IN])
    else $error("slow input pin kept gpio");
  AST_SLOW_XTAL: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_take && !osc_q[`PPM_F_SBYP]) |=> slow_osc_crystal
    && !pad_oe[`PPM_PIN_SLOW_OUT] && !pad_ie[`PPM_PIN_SLOW_OUT])
    else $error("slow crystal mode not set");
  AST_SLOW_BYP: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_take && osc_q[`PPM_F_SBYP] && selhi_q[`PPM_PIN_SLOW_OUT] == 1'h0
    && sello_q[`PPM_PIN_SLOW_OUT] == 1'h0) |=> slow_osc_ext_clock
    && pad_ie[`PPM_PIN_SLOW_IN] && pad_ie[`PPM_PIN_SLOW_OUT])
    else $error("slow bypass mode wrong");
  AST_SLOW_OUT_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
    ((selhi_q[`PPM_PIN_SLOW_OUT] || sello_q[`PPM_PIN_SLOW_OUT]) && !s_tout)
    |=> !pad_ie[`PPM_PIN_SLOW_OUT] && !pad_out[`PPM_PIN_SLOW_OUT]
    && pad_oe[`PPM_PIN_SLOW_OUT] == $past(dir_q[`PPM_PIN_SLOW_OUT]))
    else $error("slow output pin not tied low");
  AST_FAST_TAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    f_take |=> !pad_oe[`PPM_PIN_FAST_IN] && !gpio_in[`PPM_PIN_FAST_IN])
    else $error("fast input pin kept gpio");
  AST_FAST_XTAL: assert property (@(posedge hclk) disable iff (!hresetn)
    (f_take && !osc_q[`PPM_F_FBYP]) |=> fast_osc_crystal
    && !pad_oe[`PPM_PIN_FAST_OUT] && !pad_ie[`PPM_PIN_FAST_OUT])
    else $error("fast crystal mode not set");
  AST_FAST_BYP: assert property (@(posedge hclk) disable iff (!hresetn)
    (f_take && osc_q[`PPM_F_FBYP]) |=> fast_osc_ext_clock
    && pad_ie[`PPM_PIN_FAST_IN] && !fast_osc_crystal)
    else $error("fast bypass mode wrong");
  AST_FAST_OUT_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
    ((selhi_q[`PPM_PIN_FAST_OUT] || sello_q[`PPM_PIN_FAST_OUT]) && !f_tout)
    |=> !pad_ie[`PPM_PIN_FAST_OUT] && !pad_out[`PPM_PIN_FAST_OUT]
    && pad_oe[`PPM_PIN_FAST_OUT] == $past(dir_q[`PPM_PIN_FAST_OUT]))
    else $error("fast output pin not tied low");

endmodule // ppm_top

`default_nettype wire

// ===== core/ppm_params.svh
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// ==========================================================================
// Pin count and pin indices.
`define PPM_NPIN 26
`define PPM_PIN_SLOW_IN 22
`define PPM_PIN_SLOW_OUT 23
`define PPM_PIN_FAST_IN 24
`define PPM_PIN_FAST_OUT 25
`define PPM_NCMP 16

// ==========================================================================
// Bus constants.
`define PPM_AW 8
`define PPM_DW 32
`define PPM_HSIZE_WORD 3'h2
`define PPM_HTRANS_NSEQ_BIT 1
`define PPM_RST_WORD 32'h0

// ==========================================================================
// Register offsets.
`define PPM_OFF_DIR 8'h00
`define PPM_OFF_SELLO 8'h04
`define PPM_OFF_SELHI 8'h08
`define PPM_OFF_GOUT 8'h0c
`define PPM_OFF_CPD 8'h10
`define PPM_OFF_CSEL 8'h14
`define PPM_OFF_OSC 8'h18
`define PPM_OFF_GIN 8'h1c

// ==========================================================================
// Field positions.
`define PPM_F_CPOS 3:0
`define PPM_F_CNEG 7:4
`define PPM_F_CPEN 8
`define PPM_F_CNEN 9
`define PPM_CSEL_W 10
`define PPM_F_SBYP 0
`define PPM_F_FBYP 1
`define PPM_OSC_W 2

`endif

// ===== core/ppm_pkg.sv
`default_nettype none

package ppm_pkg;

  // ========================================================================
  // Function offered by one select code of one pin.
  typedef enum logic [2:0] {
    PPM_NO = 3'h0,
    PPM_TM = 3'h1,
    PPM_OO = 3'h2,
    PPM_SR = 3'h3,
    PPM_AN = 3'h4
  } ppm_kind_e;

  // ========================================================================
  // Per pin: functions for select 01, 10, 11 and comparator channel.
  typedef struct packed {
    ppm_kind_e ka;
    ppm_kind_e kb;
    ppm_kind_e kc;
    logic [4:0] cch;
  } ppm_pin_s;

endpackage

`default_nettype wire

// ===== core/ppm_osc_sel.sv
`default_nettype none

module ppm_osc_sel (
  input wire logic in_sel_hi,
  input wire logic in_sel_lo,
  input wire logic bypass,
  output logic take_in,
  output logic in_ie,
  output logic take_out,
  output logic crystal,
  output logic ext_clock
);

  // ========================================================================
  // Oscillator ownership of the input and output pins.
  always_comb begin
    take_in = !in_sel_hi && in_sel_lo;
    in_ie = take_in && bypass;
    take_out = take_in && !bypass;
    crystal = take_out;
    ext_clock = in_ie;
  end

endmodule // ppm_osc_sel

`default_nettype wire

// ===== core/ppm_pin_cell.sv
`default_nettype none

module ppm_pin_cell (
  input wire logic hclk,
  input wire logic hresetn,
  input wire ppm_pkg::ppm_pin_s tbl,
  input wire logic dir,
  input wire logic sel_hi,
  input wire logic sel_lo,
  input wire logic gpio_out,
  input wire logic alt_a_out,
  input wire logic alt_b_out,
  input wire logic serial_oe,
  input wire logic cmp_off,
  input wire logic osc_take,
  input wire logic osc_ie,
  input wire logic pad_in,
  output logic pad_out_q,
  output logic pad_oe_q,
  output logic pad_ie_q,
  output logic gpio_in_q,
  output logic func_in_q,
  output logic analog_en_q
);
  import ppm_pkg::*;

  ppm_kind_e kind;
  logic alt;
  logic out_d, oe_d, ie_d, gin_d, fin_d, an_d;

  // ========================================================================
  // Function selection.
  always_comb begin
    kind = PPM_NO;
    alt = alt_b_out;
    out_d = 1'h0;
    oe_d = 1'h0;
    ie_d = 1'h0;
    gin_d = 1'h0;
    fin_d = 1'h0;
    an_d = 1'h0;
    case ({sel_hi, sel_lo})
      2'h1: begin
        kind = tbl.ka;
        alt = alt_a_out;
      end
      2'h2: kind = tbl.kb;
      2'h3: kind = tbl.kc;
      default: kind = PPM_NO;
    endcase
    if (osc_take) begin
      ie_d = osc_ie;
      fin_d = osc_ie && pad_in;
    end else if (cmp_off) begin
      an_d = 1'h1;
    end else if ({sel_hi, sel_lo} == 2'h0) begin
      oe_d = dir;
      out_d = gpio_out;
      ie_d = 1'h1;
      gin_d = pad_in;
    end else begin
      case (kind)
        PPM_TM: begin
          oe_d = dir;
          out_d = dir && alt;
          ie_d = !dir;
          fin_d = !dir && pad_in;
        end
        PPM_OO: begin
          oe_d = dir;
          out_d = dir && alt;
        end
        PPM_SR: begin
          oe_d = serial_oe;
          out_d = alt;
          ie_d = 1'h1;
          fin_d = pad_in;
        end
        PPM_AN: an_d = 1'h1;
        default: oe_d = dir;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out_q <= 1'h0;
      pad_oe_q <= 1'h0;
      pad_ie_q <= 1'h0;
      gpio_in_q <= 1'h0;
      func_in_q <= 1'h0;
      analog_en_q <= 1'h0;
    end else begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
      pad_ie_q <= ie_d;
      gpio_in_q <= gin_d;
      func_in_q <= fin_d;
      analog_en_q <= an_d;
    end
  end

  // ========================================================================
  // Checks.
  AST_GPIO_DIR: assert property (@(posedge hclk) disable iff (!hresetn)
    ({sel_hi, sel_lo} == 2'h0 && !osc_take && !cmp_off)
    |=> pad_oe_q == $past(dir) && pad_ie_q)
    else $error("gpio direction not followed");
  AST_ANALOG_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel_hi && sel_lo && tbl.kc == PPM_AN && !osc_take)
    |=> !pad_oe_q && !pad_ie_q && analog_en_q)
    else $error("analog pin still driven or sensed");
  AST_SERIAL_DIR: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel_hi && !sel_lo && tbl.kb == PPM_SR && !osc_take && !cmp_off)
    |=> pad_oe_q == $past(serial_oe) && pad_ie_q)
    else $error("serial pin direction not from serial unit");
  AST_NO_FUNC: assert property (@(posedge hclk) disable iff (!hresetn)
    ({sel_hi, sel_lo} != 2'h0 && kind == PPM_NO && !osc_take && !cmp_off)
    |=> !pad_ie_q && !pad_out_q && pad_oe_q == $past(dir))
    else $error("empty function not tied low");
  AST_CMP_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmp_off && !osc_take) |=> !pad_oe_q && !pad_ie_q)
    else $error("comparator pin not released");

endmodule // ppm_pin_cell

`default_nettype wire

// ===== sim/ppm_pad_model.sv
`default_nettype none

module ppm_pad_model (
  input wire logic hclk,
  input wire logic [25:0] pad_out,
  input wire logic [25:0] pad_oe,
  input wire logic [25:0] ext_val,
  input wire logic [25:0] ext_en,
  output logic [25:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================================================
  // Pad levels.
  logic [25:0] flt_q = 26'h0;
  logic [25:0] flt_d;

  always_comb begin
    flt_d = ~flt_q;
  end

  always_ff @(posedge hclk) begin
    flt_q <= flt_d;
  end

  // An undriven pad has no pull, so it shows a level that flips each cycle.
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
      (~pad_oe & ~ext_en & flt_q);
  end
endmodule // ppm_pad_model

`default_nettype wire

// ===== sim/tb_top.sv
`include "ppm_params.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ppm_pkg::*;

  // ========================================================================
  // Signals.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [25:0] alt_a = 26'h0;
  logic [25:0] alt_b = 26'h0;
  logic [25:0] ser_oe = 26'h0;
  logic [25:0] ext_val = 26'h0;
  logic [25:0] ext_en = 26'h3ffffff;
  wire logic hready;
  logic hreadyout, hresp, so_c, so_e, fo_c, fo_e;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [25:0] pad_in, pad_out, pad_oe, pad_ie;
  logic [25:0] gpio_in, func_in, analog_en;
  int error_cnt = 0;
  int comparisons = 0;
  int analog_pins[10] = '{1, 2, 6, 7, 8, 9, 14, 15, 16, 17};

  always #4 hclk = ~hclk;
  assign hready = hreadyout;

  ppm_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .alt_a_out(alt_a), .alt_b_out(alt_b),
    .serial_oe(ser_oe), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_ie(pad_ie), .gpio_in(gpio_in),
    .func_in(func_in), .analog_en(analog_en),
    .slow_osc_crystal(so_c), .slow_osc_ext_clock(so_e),
    .fast_osc_crystal(fo_c), .fast_osc_ext_clock(fo_e)
  );

  ppm_pad_model i_pads (
    .hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in)
  );

  // ========================================================================
  // Tasks.
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ppin(input int i, input logic [3:0] e);
    chk("pin oe,out,ie,an", {28'h0, e},
        {28'h0, pad_oe[i], pad_out[i], pad_ie[i], analog_en[i]});
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("hrdata", e, rd);
  endtask

  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask

  task automatic cfg(input logic [25:0] dir, input logic [25:0] lo,
                     input logic [25:0] hi);
    bus(1'b1, `PPM_OFF_DIR, {6'h0, dir});
    bus(1'b1, `PPM_OFF_SELLO, {6'h0, lo});
    bus(1'b1, `PPM_OFF_SELHI, {6'h0, hi});
    settle();
  endtask

  // ========================================================================
  // Sequence.
  initial begin
    int p;
    logic [1:0] fl;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("pad_oe", 32'h0, {6'h0, pad_oe});
    chk("pad_ie", 32'h3ffffff, {6'h0, pad_ie});
    rdc(`PPM_OFF_DIR, 32'h0);
    rdc(`PPM_OFF_OSC, 32'h0);
    bus(1'b1, 8'h20, 32'hffffffff);
    rdc(8'h20, 32'h0);
    ext_val <= 26'h2aaaaaa;
    settle();
    chk("gpio_in", 32'h2aaaaaa, {6'h0, gpio_in});
    rdc(`PPM_OFF_GIN, 32'h2aaaaaa);
    bus(1'b1, `PPM_OFF_GOUT, 32'h1555555);
    cfg(26'h3ffffff, 26'h0, 26'h0);
    chk("pad_oe", 32'h3ffffff, {6'h0, pad_oe});
    chk("pad_out", 32'h1555555, {6'h0, pad_out});
    bus(1'b1, `PPM_OFF_GOUT, 32'h0);
    cfg(26'h3fffff7, 26'h0bc3ce, 26'h07c3ee);
    foreach (analog_pins[j]) ppin(analog_pins[j], 4'h1);
    ppin(3, 4'h0);
    ppin(5, 4'h8);
    ppin(18, 4'h8);
    ppin(19, 4'h8);
    ppin(0, 4'ha);
    cfg(26'h3ffffff, 26'h0, 26'h0);
    bus(1'b1, `PPM_OFF_CPD, 32'h400);
    settle();
    ppin(1, 4'h1);
    ppin(2, 4'ha);
    bus(1'b1, `PPM_OFF_CPD, 32'h0);
    bus(1'b1, `PPM_OFF_CSEL, 32'h3cb);
    settle();
    ppin(2, 4'h1);
    ppin(6, 4'h1);
    ppin(1, 4'ha);
    bus(1'b1, `PPM_OFF_CSEL, 32'h0);
    // Pins 0 to 4 go to the serial units; no clock output is chosen.
    alt_b <= 26'h3ffffff;
    ser_oe <= 26'h15;
    cfg(26'h0, 26'h0, 26'h1f);
    chk("pad_oe", 32'h15, {27'h0, pad_oe[4:0]});
    chk("pad_out", 32'h15, {27'h0, pad_out[4:0] & 5'h15});
    ser_oe <= 26'h0a;
    bus(1'b1, `PPM_OFF_DIR, 32'h3ffffff);
    settle();
    chk("pad_oe", 32'h0a, {27'h0, pad_oe[4:0]});
    ser_oe <= 26'h0;
    ext_val <= 26'h3ffffff;
    bus(1'b1, `PPM_OFF_GOUT, 32'h3ffffff);
    for (int k = 0; k < 2; k++) begin
      p = 22 + 2 * k;
      bus(1'b1, `PPM_OFF_OSC, 32'h0);
      cfg(26'h3ffffff, 26'h3 << p, 26'h2 << p);
      fl = k == 0 ? {so_c, so_e} : {fo_c, fo_e};
      chk("osc mode", 32'h2, {30'h0, fl});
      chk("osc pins", 32'h0, {28'h0, pad_oe[p +: 2], pad_ie[p +: 2]});
      bus(1'b1, `PPM_OFF_OSC, 32'h1 << k);
      cfg(26'h3ffffff, 26'h1 << p, 26'h0);
      fl = k == 0 ? {so_c, so_e} : {fo_c, fo_e};
      chk("osc mode", 32'h1, {30'h0, fl});
      chk("bypass in", 32'h3, {30'h0, pad_ie[p], func_in[p]});
      ppin(p + 1, 4'he);
      bus(1'b1, `PPM_OFF_OSC, 32'h0);
      cfg(26'h3ffffff, 26'h2 << p, 26'h0);
      ppin(p + 1, 4'h8);
      chk("gpio_in", 32'h0, {31'h0, gpio_in[p + 1]});
      ppin(p, 4'he);
    end
    alt_a <= 26'h3ffffff;
    cfg(26'h0, 26'h3, 26'h0);
    ppin(0, 4'h0);
    print_verdict();
  end

endmodule // tb_top

`default_nettype wire
